/* dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic host_cpu_reset_n,
    input  wire logic quiet,
    output logic      eeprom_clock_line,
    output logic      eeprom_clock_line_write
);
    logic [7:0] cnt_r;
    // Host in reset leaves the line to its pull-down; quiet never writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn || !host_cpu_reset_n) begin
            cnt_r                   <= 8'h00;
            eeprom_clock_line       <= 1'b0;
            eeprom_clock_line_write <= 1'b0;
        end else if (!quiet) begin
            cnt_r                   <= cnt_r + 8'h01;
            eeprom_clock_line       <= 1'b1;
            eeprom_clock_line_write <= (cnt_r >= 8'h28 && cnt_r < 8'h2C);
        end
    end
endmodule

/* dv/power_reset_sequencer_tb.sv */
`timescale 1ns/1ps
module power_reset_sequencer_tb;
    localparam int unsigned DSP_DELAY  = 20;
    localparam int unsigned HOST_DELAY = 10;
    logic clk, rstn, unregulated_supply, seq_osc, quiet, eline, ewrite;
    logic dsp_reset_n, serial_port_reset, host_cpu_reset_n;
    logic outreg_enable_n, output_mute_n, sw_l, sw_r;
    logic [2:0] osc_cnt;
    int mismatches, num_checks, n;
    power_reset_sequencer #(.DSP_DELAY(DSP_DELAY), .HOST_DELAY(HOST_DELAY))
        dut_u (.clk(clk), .rstn(rstn), .unregulated_supply(unregulated_supply),
        .seq_osc(seq_osc), .eeprom_clock_line(eline),
        .eeprom_clock_line_write(ewrite), .dsp_reset_n(dsp_reset_n),
        .serial_port_reset(serial_port_reset),
        .host_cpu_reset_n(host_cpu_reset_n), .outreg_enable_n(outreg_enable_n),
        .output_mute_n(output_mute_n), .mute_switch_left(sw_l),
        .mute_switch_right(sw_r));
    host_model host_u (.clk(clk), .rstn(rstn), .host_cpu_reset_n(host_cpu_reset_n),
        .quiet(quiet), .eeprom_clock_line(eline), .eeprom_clock_line_write(ewrite));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Oscillator of eight clocks, slow enough for the synchroniser
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        seq_osc <= osc_cnt[2];
    end
    task automatic chk_bit(string nm, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic chk_range(string nm, int lo, int hi, int got);
        num_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    // Counts settled cycles until the chosen output goes high
    task automatic wait_hi(int sel);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((sel == 0 ? dsp_reset_n : sel == 1 ? host_cpu_reset_n
                    : output_mute_n) !== 1'b1 && n < 300);
    endtask
    task automatic t_powerup;
        wait_hi(0);
        chk_range("dsp_delay", DSP_DELAY, DSP_DELAY + 20, n);
        chk_bit("serial_reset", 1'b0, serial_port_reset);
        wait_hi(1);
        chk_range("host_delay", HOST_DELAY, HOST_DELAY + 20, n);
        chk_bit("outreg_enable_n", 1'b0, outreg_enable_n);
        repeat (30) @(negedge clk);
        chk_bit("mute_blocked", 1'b0, output_mute_n);
        wait_hi(2);
        chk_range("mute_on_write", 1, 30, n);
        chk_bit("switch_left", 1'b0, sw_l);
    endtask
    task automatic t_brownout;
        @(posedge clk);
        unregulated_supply <= 1'b0;
        quiet <= 1'b1;
        #1;
        chk_bit("drop_dsp", 1'b0, dsp_reset_n);
        chk_bit("drop_host", 1'b0, host_cpu_reset_n);
        chk_bit("drop_mute", 1'b0, output_mute_n);
        repeat (40) @(negedge clk);
        chk_bit("held_dsp", 1'b0, dsp_reset_n);
        @(posedge clk);
        unregulated_supply <= 1'b1;
    endtask
    task automatic t_line_low;
        wait_hi(0);
        chk_range("dsp_again", DSP_DELAY, DSP_DELAY + 20, n);
        wait_hi(1);
        wait_hi(2);
        chk_range("mute_line_low", 1, 24, n);
        chk_bit("switch_right", 1'b0, sw_r);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {rstn, quiet, osc_cnt, seq_osc} = '0;
        unregulated_supply = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_powerup;
        t_brownout;
        t_line_low;
        results;
    end
    // Whole run is a few hundred clocks
    initial begin
        #100us;
        mismatches++;
        results;
    end
endmodule
bind power_reset_sequencer prs_asserts #(.DSP_DELAY(DSP_DELAY),
    .HOST_DELAY(HOST_DELAY)) chk_u (.clk(clk), .rstn(rstn),
    .unregulated_supply(unregulated_supply), .dsp_reset_n(dsp_reset_n),
    .serial_port_reset(serial_port_reset), .host_cpu_reset_n(host_cpu_reset_n),
    .outreg_enable_n(outreg_enable_n), .output_mute_n(output_mute_n),
    .mute_switch_left(mute_switch_left), .mute_switch_right(mute_switch_right));

/* dv/prs_asserts.sv */
`timescale 1ns/1ps
module prs_asserts #(
    parameter int unsigned DSP_DELAY  = 20,
    parameter int unsigned HOST_DELAY = 10
) (
    // Clock, reset and supply
    input wire logic clk,
    input wire logic rstn,
    input wire logic unregulated_supply,
    // Sequencer outputs
    input wire logic dsp_reset_n,
    input wire logic serial_port_reset,
    input wire logic host_cpu_reset_n,
    input wire logic outreg_enable_n,
    input wire logic output_mute_n,
    input wire logic mute_switch_left,
    input wire logic mute_switch_right
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Every output except the two mute switches in its power-down state
    sequence s_all_reset;
        !dsp_reset_n && serial_port_reset && !host_cpu_reset_n
            && outreg_enable_n && !output_mute_n;
    endsequence
    AST_DROP_ALL: assert property (!unregulated_supply |-> s_all_reset)
        else $error("supply low without full reset");
    AST_DSP_UART: assert property (dsp_reset_n == !serial_port_reset)
        else $error("processor and serial resets split");
    AST_HOST_EN: assert property (host_cpu_reset_n == !outreg_enable_n)
        else $error("host reset and output enable split");
    AST_HOST_WAIT: assert property ($rose(dsp_reset_n) |-> !host_cpu_reset_n[*8])
        else $error("host released too early");
    AST_ORDER: assert property (output_mute_n |-> host_cpu_reset_n)
        else $error("mute released before host");
    AST_MUTE_AFTER: assert property ($rose(output_mute_n) |-> $past(host_cpu_reset_n, 2))
        else $error("mute released without host stage");
    AST_SWITCH: assert property (mute_switch_left == !output_mute_n && mute_switch_right == !output_mute_n)
        else $error("ground switches disagree with mute");
    AST_HOLD: assert property (dsp_reset_n && unregulated_supply |=> dsp_reset_n || !unregulated_supply)
        else $error("reset returned with supply good");
endmodule

/* rtl/power_reset_sequencer.sv */
`timescale 1ns/1ps
module power_reset_sequencer
    import seq_pkg::*;
#(
    parameter int unsigned DSP_DELAY  = DSP_DELAY_CYC,
    parameter int unsigned HOST_DELAY = HOST_DELAY_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Supply and oscillator pins
    input  wire logic unregulated_supply,
    input  wire logic seq_osc,
    // Host-driven EEPROM lines
    input  wire logic eeprom_clock_line,
    input  wire logic eeprom_clock_line_write,
    // Reset outputs
    output logic      dsp_reset_n,
    output logic      serial_port_reset,
    output logic      host_cpu_reset_n,
    output logic      outreg_enable_n,
    // Mute outputs
    output logic      output_mute_n,
    output logic      mute_switch_left,
    output logic      mute_switch_right
);
    logic [SYNC_W-1:0] sync_q;
    logic              supply_s;
    logic              osc_s;
    logic              eline_s;
    logic              ewrite_s;
    logic              osc_d_r;
    logic              ewrite_d_r;
    logic              seq_rst_n;
    logic              osc_tick;
    logic              latch_clk_en;
    logic              ewrite_evt;
    seq_state_t        state_r;
    seq_state_t        state_nxt;
    logic [CNT_W-1:0]  dly_cnt_r;
    logic [1:0]        low_cnt_r;
    logic              dly_done;

    // All pins cross into the clk domain first, apart from the raw supply feeding the asynchronous clear
    seq_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk   (clk),
        .rstn  (rstn),
        .d_in  ({eeprom_clock_line_write, eeprom_clock_line,
                 seq_osc, unregulated_supply}),
        .q_out (sync_q)
    );

    assign supply_s = sync_q[SY_SUPPLY];
    assign osc_s    = sync_q[SY_OSC];
    assign eline_s  = sync_q[SY_ELINE];
    assign ewrite_s = sync_q[SY_EWRITE];

    // Raw supply drop clears the latch without waiting for a clock edge
    assign seq_rst_n = rstn & unregulated_supply;

    // Edge history for oscillator and write strobe
    always_ff @(posedge clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            osc_d_r    <= 1'b0;
            ewrite_d_r <= 1'b0;
        end else begin
            osc_d_r    <= osc_s;
            ewrite_d_r <= ewrite_s;
        end
    end

    // Oscillator rising edge, only while supply is good
    assign osc_tick   = osc_s & ~osc_d_r & supply_s;
    assign ewrite_evt = ewrite_s & ~ewrite_d_r;
    // Line low (pull-down default) lets the tick through; host high stops it
    assign latch_clk_en = osc_tick & ~eline_s;

    // Delay counter restarts at every stage step
    always_ff @(posedge clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            dly_cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            dly_cnt_r <= '0;
        end else if (!dly_done) begin
            dly_cnt_r <= dly_cnt_r + 1'b1;
        end
    end

    always_comb begin
        case (state_r)
            ST_ALL_RESET: dly_done = (dly_cnt_r >= DSP_DELAY);
            ST_DSP_UP:    dly_done = (dly_cnt_r >= HOST_DELAY);
            default:      dly_done = 1'b1;
        endcase
    end

    // Oscillator periods with the line held low, once the host is up
    always_ff @(posedge clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            low_cnt_r <= '0;
        end else if (state_r != ST_HOST_UP || eline_s) begin
            low_cnt_r <= '0;
        end else if (osc_tick && low_cnt_r < 2'(MUTE_LOW_PERIODS)) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    // Each stage feeds the next; steps on the gated oscillator tick, and the last step also on a write strobe or the low count
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_ALL_RESET: begin
                if (latch_clk_en && dly_done) begin
                    state_nxt = ST_DSP_UP;
                end
            end
            ST_DSP_UP: begin
                if (latch_clk_en && dly_done) begin
                    state_nxt = ST_HOST_UP;
                end
            end
            ST_HOST_UP: begin
                // Host holding the line high blocks the tick path here
                if (latch_clk_en || ewrite_evt ||
                    low_cnt_r >= 2'(MUTE_LOW_PERIODS)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: state_nxt = ST_RUN;
            default: state_nxt = ST_ALL_RESET;
        endcase
    end

    // Stage latch
    always_ff @(posedge clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            state_r <= ST_ALL_RESET;
        end else if (!supply_s) begin
            state_r <= ST_ALL_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered reset outputs; all assert together on supply drop
    always_ff @(posedge clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            dsp_reset_n       <= 1'b0;
            serial_port_reset <= 1'b1;
            host_cpu_reset_n  <= 1'b0;
            outreg_enable_n   <= 1'b1;
        end else begin
            dsp_reset_n       <= (state_r != ST_ALL_RESET);
            serial_port_reset <= (state_r == ST_ALL_RESET);
            host_cpu_reset_n  <= (state_r == ST_HOST_UP) ||
                                 (state_r == ST_RUN);
            outreg_enable_n   <= !((state_r == ST_HOST_UP) ||
                                   (state_r == ST_RUN));
        end
    end

    // Mute outputs; switches close to ground while the mute is low
    always_ff @(posedge clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            output_mute_n     <= 1'b0;
            mute_switch_left  <= 1'b1;
            mute_switch_right <= 1'b1;
        end else begin
            output_mute_n     <= (state_r == ST_RUN);
            mute_switch_left  <= (state_r != ST_RUN);
            mute_switch_right <= (state_r != ST_RUN);
        end
    end
endmodule

/* rtl/seq_sync.sv */
`timescale 1ns/1ps
package seq_pkg;
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
    localparam int unsigned DSP_DELAY_MS     = 230;
    localparam int unsigned HOST_DELAY_MS    = 70;
    localparam int unsigned DSP_DELAY_CYC    = DSP_DELAY_MS * CYC_PER_MS;
    localparam int unsigned HOST_DELAY_CYC   = HOST_DELAY_MS * CYC_PER_MS;
    localparam int unsigned MUTE_LOW_PERIODS = 2;
    localparam int unsigned CNT_W            = 32;
    localparam int unsigned SYNC_W           = 4;
    // Positions inside the synchroniser vector
    localparam int unsigned SY_SUPPLY        = 0;
    localparam int unsigned SY_OSC           = 1;
    localparam int unsigned SY_ELINE         = 2;
    localparam int unsigned SY_EWRITE        = 3;
    localparam logic [3:0]  SYNC_RST         = 4'h0;

    typedef enum logic [1:0] {
        ST_ALL_RESET,
        ST_DSP_UP,
        ST_HOST_UP,
        ST_RUN
    } seq_state_t;
endpackage

module seq_sync
    import seq_pkg::*;
#(
    parameter int unsigned W = SYNC_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // Two-flop synchroniser; only the second flop is read outside
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule
